// ### hw/ioxp_target.sv
// Expander end: bus target, register file and port pin logic
`timescale 1ns/1ps
module ioxp_target (
  input  wire logic       mclk,
  input  wire logic       rst,
  ioxp_bus_if.dev         bus,
  input  wire logic       addr_strap_bit0,
  input  wire logic       addr_strap_bit1,
  input  wire logic       addr_strap_bit2,
  input  wire logic [7:0] port_pin_bits,
  output logic      [7:0] drive_level_bits,
  output logic      [7:0] port_oe,
  output logic            change_alert_n
);
  typedef enum {IOXP_IDLE, IOXP_ADDR, IOXP_PTR, IOXP_WDATA, IOXP_RDATA, IOXP_SKIP} ioxp_state_t;
  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [23:0] pin_s;
    logic [7:0]  pin_prev;
    ioxp_state_t st;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic        acking;
    logic        rd_dir;
    logic        mnack;
    logic [7:0]  pointer;
    logic [7:0]  sampled_level_bits;
    logic [7:0]  drive;
    logic [7:0]  invert_bits;
    logic [7:0]  direction_bits;
    logic        alert;
    logic        sda_o;
    logic        sda_oe;
  } ioxp_tgt_t;
  ioxp_tgt_t r;
  ioxp_tgt_t next_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [7:0] pins_now;
  logic [7:0] sel_data;
  // ----------------------------------------
  // Synchronised edges
  // ----------------------------------------
  assign scl_rise = r.scl_s[1] && r.scl_s[2] == 1'b0 && r.scl_s[1] != r.scl_s[2];
  assign scl_fall = !r.scl_s[1] && r.scl_s[2];
  assign start_c  = r.scl_s[1] && r.scl_s[2] && !r.sda_s[1] && r.sda_s[2];
  assign stop_c   = r.scl_s[1] && r.scl_s[2] && r.sda_s[1] && !r.sda_s[2];
  always_comb begin
    pins_now = '0;
    for (int i = 0; i < 8; i++) begin
      pins_now[i] = r.pin_s[8 + i];
    end
  end
  always_comb begin
    case (r.pointer[1:0])
      ioxp_pkg::REG_PIN_LEVEL: sel_data = r.sampled_level_bits ^ r.invert_bits;
      ioxp_pkg::REG_DRIVE:     sel_data = r.drive;
      ioxp_pkg::REG_INVERT:    sel_data = r.invert_bits;
      default:                 sel_data = r.direction_bits;
    endcase
  end
  always_comb begin
    next_r = r;
    next_r.scl_s = {r.scl_s[1:0], bus.scl};
    next_r.sda_s = {r.sda_s[1:0], bus.sda};
    for (int i = 0; i < 8; i++) begin
      next_r.pin_s[i]      = port_pin_bits[i];
      next_r.pin_s[8 + i]  = r.pin_s[i];
      next_r.pin_s[16 + i] = r.pin_s[8 + i];
    end
    if (((pins_now ^ r.pin_prev) & r.direction_bits) != 8'h00) begin
      next_r.alert = 1'b1;
    end
    next_r.pin_prev = pins_now;
    if (start_c) begin
      next_r.st     = IOXP_ADDR;
      // The clock fall that ends a start wraps this to bit zero
      next_r.bitn   = 4'hf;
      next_r.acking = 1'b0;
      next_r.sda_oe = 1'b0;
    end else if (stop_c) begin
      next_r.st     = IOXP_IDLE;
      next_r.sda_oe = 1'b0;
    end else if (r.st != IOXP_IDLE && r.st != IOXP_SKIP) begin
      if (scl_rise) begin
        if (r.bitn <= ioxp_pkg::BIT_LAST) begin
          next_r.shreg = {r.shreg[6:0], r.sda_s[1]};
        end else begin
          next_r.mnack = r.sda_s[1];
          if (r.st == IOXP_RDATA || (r.st == IOXP_ADDR && r.shreg[0] == ioxp_pkg::DIR_READ)) begin
            next_r.sampled_level_bits = pins_now;
            if (r.pointer[1:0] == ioxp_pkg::REG_PIN_LEVEL) begin
              next_r.alert = 1'b0;
            end
          end
        end
      end
      if (scl_fall) begin
        next_r.bitn   = r.bitn + 4'h1;
        next_r.sda_oe = 1'b0;
        if (r.bitn == ioxp_pkg::BIT_LAST && r.st != IOXP_RDATA) begin
          case (r.st)
            IOXP_ADDR: begin
              if (r.shreg[7:1] == {ioxp_pkg::ADDR_HI, addr_strap_bit2, addr_strap_bit1,
                                   addr_strap_bit0}) begin
                next_r.sda_oe = 1'b1;
                next_r.sda_o  = 1'b0;
                next_r.rd_dir = r.shreg[0];
              end else begin
                next_r.st = IOXP_SKIP;
              end
            end
            IOXP_PTR: begin
              next_r.pointer = r.shreg;
              next_r.sda_oe  = 1'b1;
              next_r.sda_o   = 1'b0;
            end
            IOXP_WDATA: begin
              next_r.sda_oe = 1'b1;
              next_r.sda_o  = 1'b0;
              case (r.pointer[1:0])
                ioxp_pkg::REG_PIN_LEVEL: next_r.drive = r.drive;
                ioxp_pkg::REG_DRIVE:     next_r.drive = r.shreg;
                ioxp_pkg::REG_INVERT:    next_r.invert_bits = r.shreg;
                default:                 next_r.direction_bits = r.shreg;
              endcase
            end
            default: next_r.sda_oe = 1'b0;
          endcase
        end else if (r.bitn == ioxp_pkg::BIT_ACK) begin
          next_r.bitn = 4'h0;
          case (r.st)
            IOXP_ADDR: next_r.st = r.rd_dir ? IOXP_RDATA : IOXP_PTR;
            IOXP_PTR:  next_r.st = IOXP_WDATA;
            IOXP_RDATA: begin
              if (r.mnack) begin
                next_r.st = IOXP_SKIP;
              end
            end
            default:   next_r.st = r.st;
          endcase
          if ((r.st == IOXP_ADDR && r.rd_dir) || (r.st == IOXP_RDATA && !r.mnack)) begin
            next_r.sda_oe = !sel_data[7];
            next_r.sda_o  = 1'b0;
          end
        end else if (r.st == IOXP_RDATA && r.bitn < ioxp_pkg::BIT_LAST) begin
          next_r.sda_oe = !sel_data[3'h6 - r.bitn[2:0]];
          next_r.sda_o  = 1'b0;
        end
      end
    end
    if (rst) begin
      next_r                    = '0;
      next_r.st                 = IOXP_IDLE;
      next_r.scl_s              = 3'h7;
      next_r.sda_s              = 3'h7;
      // Preload pin history so release of reset shows no false edge
      next_r.pin_s              = {3{port_pin_bits}};
      next_r.pin_prev           = port_pin_bits;
      next_r.pointer            = ioxp_pkg::PTR_RESET;
      next_r.drive              = ioxp_pkg::DRIVE_RESET;
      next_r.invert_bits        = ioxp_pkg::INVERT_RESET;
      next_r.direction_bits     = ioxp_pkg::DIR_RESET;
      next_r.sda_o              = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    r <= next_r;
  end
  assign bus.sda_dev_o  = r.sda_o;
  assign bus.sda_dev_oe = r.sda_oe;
  assign drive_level_bits = r.drive;
  assign port_oe        = ~r.direction_bits;
  assign change_alert_n = !r.alert;
endmodule // ioxp_target

// ### hw/ioxp_pkg.sv
// Shared constants for the serial I/O expander and its controller
package ioxp_pkg;
  localparam logic [3:0] ADDR_HI        = 4'h7;
  localparam logic [1:0] REG_PIN_LEVEL  = 2'h0;
  localparam logic [1:0] REG_DRIVE      = 2'h1;
  localparam logic [1:0] REG_INVERT     = 2'h2;
  localparam logic [1:0] REG_DIRECTION  = 2'h3;
  localparam logic [7:0] DRIVE_RESET    = 8'hff;
  localparam logic [7:0] INVERT_RESET   = 8'h00;
  localparam logic [7:0] DIR_RESET      = 8'hff;
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic       DIR_READ       = 1'h1;
  localparam logic       DIR_WRITE      = 1'h0;
  localparam int         MCLK_HZ        = 10000000;
  localparam int         SCL_HZ         = 100000;
  localparam int         SCL_HALF_CYC   = MCLK_HZ / (2 * SCL_HZ);
  localparam logic [3:0] BIT_LAST       = 4'h7;
  localparam logic [3:0] BIT_ACK        = 4'h8;
endpackage

// ### hw/ioxp_bus_if.sv
// Two-wire bus carrier joining the controller and the expander
`timescale 1ns/1ps
interface ioxp_bus_if;
  logic scl_o;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda;
  logic scl;
  // Open drain: any enabled low driver pulls the line
  assign scl = scl_o;
  assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));
  modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (input sda, output scl_o, output sda_host_o, output sda_host_oe);
endinterface

// ### hw/ioxp_controller.sv
// Controller end: issues pointer writes, data writes and register reads
`timescale 1ns/1ps
module ioxp_controller (
  input  wire logic       mclk,
  input  wire logic       rst,
  ioxp_bus_if.host        bus,
  input  wire logic       req,
  input  wire logic       req_read,
  input  wire logic [6:0] req_addr,
  input  wire logic [7:0] req_pointer,
  input  wire logic [7:0] req_data,
  output logic            busy,
  output logic            done,
  output logic            got_ack,
  output logic [7:0]      rd_data
);
  typedef enum {IOXC_IDLE, IOXC_START, IOXC_BYTE, IOXC_RESTART, IOXC_STOP} ioxc_state_t;
  typedef struct packed {
    logic [2:0]  sda_s;
    ioxc_state_t st;
    logic [7:0]  div;
    logic [1:0]  phase;
    logic [3:0]  bitn;
    logic [1:0]  byten;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic        rdop;
    logic [6:0]  addr;
    logic [7:0]  ptr;
    logic [7:0]  wdat;
    logic        scl;
    logic        sda_o;
    logic        busy;
    logic        done;
    logic        ack;
    logic [7:0]  rd;
  } ioxc_t;
  ioxc_t r;
  ioxc_t next_r;
  logic  tick;
  assign tick = r.div == 8'(ioxp_pkg::SCL_HALF_CYC - 1);
  // ----------------------------------------
  // Byte sequencer
  // ----------------------------------------
  always_comb begin
    next_r       = r;
    next_r.sda_s = {r.sda_s[1:0], bus.sda};
    next_r.done  = 1'b0;
    next_r.div   = tick ? 8'h00 : r.div + 8'h01;
    case (r.st)
      IOXC_IDLE: begin
        next_r.div = 8'h00;
        if (req) begin
          next_r.st    = IOXC_START;
          next_r.busy  = 1'b1;
          next_r.rdop  = req_read;
          next_r.addr  = req_addr;
          next_r.ptr   = req_pointer;
          next_r.wdat  = req_data;
          next_r.ack   = 1'b1;
          next_r.byten = 2'h0;
          next_r.phase = 2'h0;
        end
      end
      IOXC_START, IOXC_RESTART: if (tick) begin
        next_r.phase = r.phase + 2'h1;
        case (r.phase)
          2'h0: begin next_r.sda_o = 1'b1; next_r.scl = 1'b1; end
          2'h1: next_r.sda_o = 1'b0;
          2'h2: next_r.scl = 1'b0;
          default: begin
            next_r.tx    = {r.addr, r.st == IOXC_RESTART ? ioxp_pkg::DIR_READ : ioxp_pkg::DIR_WRITE};
            next_r.st    = IOXC_BYTE;
            next_r.bitn  = 4'h0;
            next_r.phase = 2'h0;
          end
        endcase
      end
      IOXC_BYTE: if (tick) begin
        next_r.phase = r.phase + 2'h1;
        case (r.phase)
          2'h0: begin
            if (r.bitn <= ioxp_pkg::BIT_LAST) begin
              next_r.sda_o = (r.byten == 2'h2) ? 1'b1 : r.tx[7];
            end else begin
              next_r.sda_o = (r.byten == 2'h2) ? 1'b1 : 1'b1;
            end
          end
          2'h1: next_r.scl = 1'b1;
          2'h2: begin
            if (r.bitn <= ioxp_pkg::BIT_LAST) begin
              next_r.rx = {r.rx[6:0], r.sda_s[2]};
            end else if (r.byten != 2'h2 && r.sda_s[2]) begin
              next_r.ack = 1'b0;
            end
            next_r.tx = {r.tx[6:0], 1'b0};
          end
          default: begin
            next_r.scl   = 1'b0;
            next_r.phase = 2'h0;
            next_r.bitn  = r.bitn + 4'h1;
            if (r.bitn == ioxp_pkg::BIT_ACK) begin
              next_r.bitn  = 4'h0;
              next_r.byten = r.byten + 2'h1;
              // write: address, pointer, data then stop; read: address, pointer, restart, read address, read data then stop
              // Byte count: 0 address, 1 pointer, 3 data or read address, 2 read data
              if (!r.ack || r.byten == 2'h2 || (r.byten == 2'h3 && !r.rdop)) begin
                next_r.st = IOXC_STOP;
                if (r.byten == 2'h2) begin
                  next_r.rd = r.rx;
                end
              end else if (r.byten == 2'h0) begin
                next_r.tx = r.ptr;
              end else if (r.byten == 2'h1 && r.rdop) begin
                next_r.st    = IOXC_RESTART;
                next_r.byten = 2'h3;
              end else if (r.byten == 2'h1) begin
                next_r.tx    = r.wdat;
                next_r.byten = 2'h3;
              end else begin
                next_r.byten = 2'h2;
              end
            end
          end
        endcase
      end
      IOXC_STOP: if (tick) begin
        next_r.phase = r.phase + 2'h1;
        case (r.phase)
          2'h0: next_r.sda_o = 1'b0;
          2'h1: next_r.scl = 1'b1;
          2'h2: next_r.sda_o = 1'b1;
          default: begin
            next_r.st   = IOXC_IDLE;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
          end
        endcase
      end
      default: next_r.st = IOXC_IDLE;
    endcase
    if (rst) begin
      next_r       = '0;
      next_r.st    = IOXC_IDLE;
      next_r.sda_s = 3'h7;
      next_r.scl   = 1'b1;
      next_r.sda_o = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    r <= next_r;
  end
  assign bus.scl_o       = r.scl;
  assign bus.sda_host_o  = 1'b0;
  assign bus.sda_host_oe = !r.sda_o;
  assign busy            = r.busy;
  assign done            = r.done;
  assign got_ack         = r.ack;
  assign rd_data         = r.rd;
endmodule // ioxp_controller

// ### verification/ioxp_bus_checker.sv
// Wire-level assertions on the two-wire link between both ends
`timescale 1ns/1ps
module ioxp_bus_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic scl_o,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  sequence start_cond;
    scl && $fell(sda);
  endsequence
  sequence stop_cond;
    scl && $rose(sda);
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_reset_idle: assert property ($fell(rst) |-> !sda_dev_oe && scl_o)
    else $error("link not idle after reset");
  a_dev_only_low: assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("expander drives data high");
  a_host_only_low: assert property (sda_host_oe |-> !sda_host_o)
    else $error("controller drives data high");
  // Expander data may only move while the clock is low, else it forges a start or stop
  a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("expander moved data while clock high");
  a_scl_high_min: assert property ($rose(scl_o) |-> scl_o [*8])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl_o) |-> !scl_o [*8])
    else $error("clock low phase too short");
  a_stop_release: assert property (stop_cond |-> !sda_dev_oe [*8])
    else $error("expander holds data after stop");
  a_start_release: assert property (start_cond |-> !$past(sda_dev_oe))
    else $error("expander caused a start");
endmodule // ioxp_bus_checker

// ### verification/ioxp_tb.sv
// Self-checking bench joining controller and expander over the link
`timescale 1ns/1ps
module ioxp_tb;
  localparam int TIMEOUT_CYC = 90000;
  logic       mclk;
  logic       rst;
  logic [2:0] strap;
  logic [7:0] ext;
  logic [7:0] port_pin_bits;
  logic [7:0] drive_level_bits;
  logic [7:0] port_oe;
  logic       change_alert_n;
  logic       req;
  logic       req_read;
  logic [6:0] req_addr;
  logic [7:0] req_pointer;
  logic [7:0] req_data;
  logic       busy;
  logic       done;
  logic       got_ack;
  logic [7:0] rd_data;
  logic [6:0] dev_addr;
  logic [7:0] drv, dir, inv;
  int         mismatches;
  int         cmp_count;
  int         cycles;

  ioxp_bus_if ioxp_bus_if_inst ();
  // Output pins show the driven level, input pins the outside level
  assign port_pin_bits = (port_oe & drive_level_bits) | (~port_oe & ext);

  ioxp_target ioxp_target_inst (.mclk(mclk), .rst(rst), .bus(ioxp_bus_if_inst),
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .port_pin_bits(port_pin_bits), .drive_level_bits(drive_level_bits),
    .port_oe(port_oe), .change_alert_n(change_alert_n));
  ioxp_controller ioxp_controller_inst (.mclk(mclk), .rst(rst), .bus(ioxp_bus_if_inst),
    .req(req), .req_read(req_read), .req_addr(req_addr), .req_pointer(req_pointer),
    .req_data(req_data), .busy(busy), .done(done), .got_ack(got_ack), .rd_data(rd_data));
  ioxp_bus_checker ioxp_bus_checker_inst (.mclk(mclk), .rst(rst),
    .scl(ioxp_bus_if_inst.scl), .scl_o(ioxp_bus_if_inst.scl_o), .sda(ioxp_bus_if_inst.sda),
    .sda_dev_o(ioxp_bus_if_inst.sda_dev_o), .sda_dev_oe(ioxp_bus_if_inst.sda_dev_oe),
    .sda_host_o(ioxp_bus_if_inst.sda_host_o), .sda_host_oe(ioxp_bus_if_inst.sda_host_oe));

  // ----------------------------------------
  // Clock, timeout and report
  // ----------------------------------------
  always #50 mclk = ~mclk;

  task automatic end_sim;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Ceiling sized for four reads and five writes with margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == TIMEOUT_CYC) begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Compare and transfer tasks
  // ----------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] p,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    req = 1'b1;
    req_read = rd;
    req_addr = a;
    req_pointer = p;
    req_data = d;
    @(negedge mclk);
    req = 1'b0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    xfer(1'b0, dev_addr, p, d);
    chk1("write ack", 1'b1, got_ack);
    chk1("busy after write", 1'b0, busy);
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    xfer(1'b1, dev_addr, p, 8'h00);
    chk1("read ack", 1'b1, got_ack);
    chk8("read data", exp, rd_data);
  endtask

  // Input register: pin levels, inverted where the mask asks
  function automatic logic [7:0] exp_input(input logic [7:0] e);
    return ((~dir & drv) | (dir & e)) ^ inv;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    req = 1'b0;
    req_read = 1'b0;
    req_addr = 7'h00;
    req_pointer = 8'h00;
    req_data = 8'h00;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    void'($urandom(32'h432a40b4));
    strap = 3'($urandom);
    ext = 8'($urandom);
    dev_addr = {ioxp_pkg::ADDR_HI, strap};
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk8("drive reset", ioxp_pkg::DRIVE_RESET, drive_level_bits);
    chk8("oe reset", 8'h00, port_oe);
    chk1("alert reset", 1'b1, change_alert_n);
    rd({6'h00, ioxp_pkg::REG_INVERT}, ioxp_pkg::INVERT_RESET);
    rd({6'h00, ioxp_pkg::REG_DIRECTION}, ioxp_pkg::DIR_RESET);
    chk1("alert quiet", 1'b1, change_alert_n);
    drv = 8'($urandom);
    dir = 8'($urandom) | 8'h01;
    inv = 8'($urandom);
    wr({6'h00, ioxp_pkg::REG_DRIVE}, drv);
    chk8("drive after write", drv, drive_level_bits);
    wr({6'h00, ioxp_pkg::REG_DIRECTION}, dir);
    chk8("oe after write", ~dir, port_oe);
    wr({6'h00, ioxp_pkg::REG_INVERT}, inv);
    // Flip outside levels; bit 0 is an input so an edge is seen
    ext = ~ext;
    repeat (20) @(negedge mclk);
    chk1("alert on edge", 1'b0, change_alert_n);
    rd({6'h00, ioxp_pkg::REG_PIN_LEVEL}, exp_input(ext));
    chk1("alert after read", 1'b1, change_alert_n);
    wr({6'h00, ioxp_pkg::REG_PIN_LEVEL}, ~drv);
    chk8("drive kept", drv, drive_level_bits);
    rd({6'h00, ioxp_pkg::REG_DRIVE}, drv);
    // Neighbour address in the same range must not be answered
    xfer(1'b0, dev_addr ^ 7'h01, {6'h00, ioxp_pkg::REG_DRIVE}, ~drv);
    chk1("foreign ack", 1'b0, got_ack);
    chk8("drive untouched", drv, drive_level_bits);
    end_sim();
  end
endmodule // ioxp_tb
